// ---- logic/rcf_flag_bit.v ----
// One sticky reset-cause flag: armed by a zero write, set by its event.
// Assumes i_event is already synchronous to i_mclk.
module rcf_flag_bit (
    input  wire i_mclk,
    input  wire i_nrst,
    input  wire i_wr,
    input  wire i_wdata,
    input  wire i_event,
    output reg  o_flag,
    output reg  o_set_pulse
);
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flag      <= 1'b1;
            o_set_pulse <= 1'b0;
        end else begin
            // The event wins over a zero write in the same cycle so it is not lost.
            if (i_event) begin
                o_flag <= 1'b1;
            end else if (i_wr) begin
                o_flag <= i_wdata;
            end
            o_set_pulse <= i_event & ~o_flag;
        end
    end
endmodule

// ---- logic/rcf_reset_cause.v ----
// Reset-cause capture register with interrupt on flag set.
// Assumes event inputs are asynchronous levels from analog monitors and the pin filter.
//
// The plain strobed port is this design's own decision.
`include "rcf_defines.vh"

module rcf_reset_cause (
    input  wire        i_mclk,
    input  wire        i_nrst,
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire        i_supply_collapse,
    input  wire        i_reset_pin_event,
    input  wire        i_io_supply_low,
    input  wire        i_main_supply_low,
    output reg  [15:0] o_rdata,
    output reg  [3:0]  o_flags,
    output reg         o_irq
);
    // ------------------------------------------------------------------------
    // Event synchronisation
    // ------------------------------------------------------------------------
    wire [3:0] ev_raw;
    wire [3:0] ev_sync;
    wire [3:0] flags;
    wire [3:0] set_pulse;
    reg  [3:0] irq_status;
    reg  [3:0] irq_mask;
    wire       wr_flags;
    reg  [3:0] next_status;

    // The comparator against reference minus one volt lives in the analog monitor.
    assign ev_raw[`RCF_BIT_COLLAPSE]  = i_supply_collapse;
    assign ev_raw[`RCF_BIT_RSTPIN]    = i_reset_pin_event;
    assign ev_raw[`RCF_BIT_IO_SUPPLY] = i_io_supply_low;
    assign ev_raw[`RCF_BIT_POR_BASE]  = i_main_supply_low;

    rcf_sync2 #(.W(`RCF_NFLAGS)) u_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (ev_raw),
        .o_sync  (ev_sync)
    );

    // ------------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------------
    assign wr_flags = i_wr & (i_addr == `RCF_OFF_FLAGS);

    genvar g;
    generate
        for (g = 0; g < `RCF_NFLAGS; g = g + 1) begin : g_flag
            // Bit 3, 2, 1, 0 set by collapse, pin, I/O supply, base supply.
            rcf_flag_bit u_bit (
                .i_mclk      (i_mclk),
                .i_nrst      (i_nrst),
                .i_wr        (wr_flags),
                .i_wdata     (i_wdata[g]),
                .i_event     (ev_sync[g]),
                .o_flag      (flags[g]),
                .o_set_pulse (set_pulse[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    always @* begin
        next_status = irq_status;
        if (i_wr && i_addr == `RCF_OFF_IRQ_STATUS) begin
            next_status = irq_status & ~i_wdata[3:0];
        end
        // A set in the clearing cycle wins.
        next_status = next_status | set_pulse;
    end

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_status <= 4'h0;
            irq_mask   <= `RCF_IRQ_MASK_RESET;
            o_irq      <= 1'b0;
            o_flags    <= `RCF_FLAGS_RESET;
            o_rdata    <= 16'h0000;
        end else begin
            irq_status <= next_status;
            if (i_wr && i_addr == `RCF_OFF_IRQ_MASK) begin
                irq_mask <= i_wdata[3:0];
            end
            o_irq   <= |(next_status & irq_mask);
            o_flags <= flags;
            if (i_rd) begin
                case (i_addr)
                    `RCF_OFF_FLAGS:      o_rdata <= {12'h000, flags};
                    `RCF_OFF_IRQ_STATUS: o_rdata <= {12'h000, irq_status};
                    `RCF_OFF_IRQ_MASK:   o_rdata <= {12'h000, irq_mask};
                    `RCF_OFF_RAW:        o_rdata <= {12'h000, ev_sync};
                    default:             o_rdata <= 16'h0000;
                endcase
            end else begin
                o_rdata <= 16'h0000;
            end
        end
    end
endmodule

// ---- logic/rcf_sync2.v ----
// Two-stage synchroniser for a group of asynchronous event levels.
// Assumes the inputs are levels held at least two clock periods.
module rcf_sync2 #(
    parameter W = 4
) (
    input  wire         i_mclk,
    input  wire         i_nrst,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync
);
    reg [W-1:0] meta;

    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta   <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// ---- shared/rcf_defines.vh ----
// Constants for the reset-cause flag block: offsets, field positions, reset values.
// Assumes a plain register port with 8-bit word addresses and 16-bit data.
//
// Functional notes
// - Bit 3 is the supply-collapse flag; an event sets it after a zero write.
// - Supply collapse means the main supply came within one volt of reference.
// - Bit 2 is the reset-pin flag; a pin reset sets it after a zero write.
// - Bit 1 is the I/O-supply flag; set when I/O supply drops below threshold.
// - Bit 0 is the base power-on flag; set when main supply drops below threshold.
// - Register sits at 70h, resets to 000fh, reserved bits read zero.
`ifndef RCF_DEFINES_VH
`define RCF_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RCF_ADDR_W          8
`define RCF_DATA_W          16
`define RCF_OFF_FLAGS       8'h70
`define RCF_OFF_IRQ_STATUS  8'h71
`define RCF_OFF_IRQ_MASK    8'h72
`define RCF_OFF_RAW         8'h73

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define RCF_NFLAGS          4
`define RCF_BIT_COLLAPSE    3
`define RCF_BIT_RSTPIN      2
`define RCF_BIT_IO_SUPPLY   1
`define RCF_BIT_POR_BASE    0
`define RCF_FLAGS_RESET     4'hf
`define RCF_IRQ_MASK_RESET  4'h0

`endif

// ---- verif/rcf_reset_cause_monitor.sv ----
// Checker for the reset-cause flag block, watching its ports only.
// Assumes o_flags trails the internal flags by one cycle.
module rcf_reset_cause_monitor (
    input logic        i_mclk,
    input logic        i_nrst,
    input logic [7:0]  i_addr,
    input logic [15:0] i_wdata,
    input logic        i_wr,
    input logic        i_rd,
    input logic        i_supply_collapse,
    input logic        i_reset_pin_event,
    input logic        i_io_supply_low,
    input logic        i_main_supply_low,
    input logic [15:0] o_rdata,
    input logic [3:0]  o_flags
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Events are held two cycles so the synchroniser is sure to see them.
    sequence ev_held(e);
        e[*2];
    endsequence
    sequence arm_wr(b);
        i_wr && i_addr == 8'h70 && !i_wdata[b];
    endsequence
    rd_map_a: assert property (i_rd && i_addr == 8'h70 |=> o_rdata == {12'h000, o_flags})
        else $error("flag read differs from flag outputs");
    rsv_zero_a: assert property (i_rd |=> o_rdata[15:4] == 12'h000)
        else $error("reserved read bits not zero");
    collapse_set_a: assert property (ev_held(i_supply_collapse) |-> ##[0:4] o_flags[3])
        else $error("collapse flag not set");
    pin_set_a: assert property (ev_held(i_reset_pin_event) |-> ##[0:4] o_flags[2])
        else $error("pin flag not set");
    io_set_a: assert property (ev_held(i_io_supply_low) |-> ##[0:4] o_flags[1])
        else $error("io supply flag not set");
    base_set_a: assert property (ev_held(i_main_supply_low) |-> ##[0:4] o_flags[0])
        else $error("base flag not set");
    flag_sticky_a: assert property ($fell(o_flags[3]) |->
        $past(i_wr && i_addr == 8'h70 && !i_wdata[3], 2))
        else $error("flag dropped without a zero write");
    arm_clear_a: assert property (arm_wr(3) ##0 (!i_supply_collapse &&
        !$past(i_supply_collapse) && !$past(i_supply_collapse, 2) &&
        !$past(i_supply_collapse, 3)) |-> ##2 !o_flags[3])
        else $error("collapse flag not cleared by zero write");
endmodule

bind rcf_reset_cause rcf_reset_cause_monitor u_mon (.i_mclk, .i_nrst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_supply_collapse, .i_reset_pin_event, .i_io_supply_low,
    .i_main_supply_low, .o_rdata, .o_flags);

// ---- verif/rcf_reset_cause_tb.sv ----
// Self-checking bench for the reset-cause flag block.
// Assumes register reads answer exactly one cycle after the strobe.
module rcf_reset_cause_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic [3:0] ev = 4'h0, o_flags;
    int mismatches = 0, total_checks = 0, cyc = 0;
    always #12.5 i_mclk = ~i_mclk;
    rcf_reset_cause u_rcf_reset_cause (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_supply_collapse(ev[3]),
        .i_reset_pin_event(ev[2]), .i_io_supply_low(ev[1]), .i_main_supply_low(ev[0]),
        .o_rdata(o_rdata), .o_flags(o_flags), .o_irq(o_irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic fire(input int b);
        @(posedge i_mclk);
        ev[b] <= 1'b1;
        repeat (3) @(posedge i_mclk);
        ev[b] <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask
    task automatic t_reset();
        rd(8'h70, 16'h000f);
        rd(8'h7f, 16'h0000);
        rd(8'h73, 16'h0000);
    endtask
    // All flags are armed together and each event is fired alone, so a wrong bit position shows as a wrong read.
    task automatic t_events();
        for (int b = 0; b < 4; b++) begin
            wr(8'h70, 16'h0000);
            rd(8'h70, 16'h0000);
            fire(b);
            rd(8'h70, 16'h0001 << b);
        end
        wr(8'h70, 16'h000f);
        rd(8'h70, 16'h000f);
    endtask
    task automatic t_irq();
        wr(8'h72, 16'h0004);
        wr(8'h70, 16'h0000);
        wr(8'h71, 16'h000f);
        fire(2);
        #1 chk({15'h0000, o_irq}, 16'h0001);
        rd(8'h71, 16'h0004);
        wr(8'h71, 16'h0004);
        repeat (2) @(posedge i_mclk);
        #1 chk({15'h0000, o_irq}, 16'h0000);
        wr(8'h70, 16'h0000);
        fire(1);
        #1 chk({15'h0000, o_irq}, 16'h0000);
        rd(8'h71, 16'h0002);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_reset();
        t_events();
        t_irq();
        report_and_stop();
    end
endmodule
